// ==== logic/ucm_pkg.sv ====
package ucm_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ           = 10_000_000;
    localparam int ATTACH_DEB_US    = 150;
    localparam int ATTACH_DEB_CYC   = (ATTACH_DEB_US * (CLK_HZ / 1_000_000));
    localparam int STARTUP_US       = 100;
    localparam int STARTUP_CYC      = (STARTUP_US * (CLK_HZ / 1_000_000));
    localparam int HV_MODE_US       = 1000;
    localparam int HV_MODE_CYC      = (HV_MODE_US * (CLK_HZ / 1_000_000));
    localparam int SYNC_LOSS_CYC    = 64;
    localparam int CNT_W            = 16;

    // ************************************************************
    // Charging modes and advertisement
    // ************************************************************
    typedef enum logic [1:0] {
        UCM_CHG_NONE,
        UCM_CHG_SDP,
        UCM_CHG_CDP,
        UCM_CHG_DCP
    } ucm_chg_t;

    localparam logic [1:0] ADV_DEFAULT = 2'h0;
    localparam logic [1:0] ADV_1A5     = 2'h1;
    localparam logic [1:0] ADV_3A      = 2'h2;

    // DCP-auto line scheme encodings
    localparam logic [1:0] DCP_DIV3    = 2'h0;
    localparam logic [1:0] DCP_1V2     = 2'h1;
    localparam logic [1:0] DCP_SHORT   = 2'h2;

    // Reset values
    localparam logic       RST_OFF     = 1'b0;
    localparam logic       RST_LOCK    = 1'b1;
    localparam logic [2:0] SYNC_RST    = 3'h0;

endpackage

// ==== logic/ucm_mode_ctrl.sv ====
`timescale 1ns/1ps

module ucm_mode_ctrl #(
    parameter bit THERM_VARIANT  = 1'b0,
    parameter int ATTACH_DEB     = ucm_pkg::ATTACH_DEB_CYC,
    parameter int STARTUP        = ucm_pkg::STARTUP_CYC,
    parameter int HV_HOLD        = ucm_pkg::HV_MODE_CYC
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    // Supply and enable pins
    input  wire logic       enable_in,
    input  wire logic       vin_undervoltage_lockout,
    input  wire logic       vcc_undervoltage_lockout,
    // CC line comparators
    input  wire logic       cc1_rd_det,
    input  wire logic       cc2_rd_det,
    input  wire logic       cc1_ra_det,
    input  wire logic       cc2_ra_det,
    // Charging mode control pins
    input  wire logic       charge_mode_select_a,
    input  wire logic       charge_mode_select_b,
    // Data line sense for DCP-auto
    input  wire logic       dline_pull_det,
    // Frequency set / sync pin
    input  wire logic       freq_set_sync_input,
    // Regulator control
    output logic            buck_enable,
    output logic            forced_continuous_pwm,
    output logic            spread_spectrum_en,
    output logic            sync_locked,
    output logic            load_switch_gate_drive,
    // Port outputs
    output logic            vconn_cc1_en,
    output logic            vconn_cc2_en,
    output logic [1:0]      cc_adv_level,
    output ucm_pkg::ucm_chg_t chg_mode,
    output logic [1:0]      dcp_scheme,
    output logic            data_switch_en,
    output logic            load_detect_output,
    output logic            plug_orientation_output
);
    import ucm_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef enum logic [2:0] {
        UCM_SHUTDOWN,
        UCM_STARTUP,
        UCM_STANDBY,
        UCM_DEBOUNCE,
        UCM_ACTIVE
    } ucm_state_t;

    typedef enum logic [1:0] {
        UCM_D_DIV3,
        UCM_D_1V2,
        UCM_D_SHORT
    } ucm_dcp_t;

    ucm_state_t      state_r;
    ucm_dcp_t        dcp_r;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] hv_cnt_r;
    logic [CNT_W-1:0] sync_cnt_r;
    logic [2:0]      en_sy_r;
    logic [2:0]      uvi_sy_r;
    logic [2:0]      uvc_sy_r;
    logic [2:0]      rd1_sy_r;
    logic [2:0]      rd2_sy_r;
    logic [2:0]      ra1_sy_r;
    logic [2:0]      ra2_sy_r;
    logic [2:0]      ma_sy_r;
    logic [2:0]      mb_sy_r;
    logic [2:0]      dl_sy_r;
    logic [2:0]      syn_sy_r;
    logic            en_q, uvi_q, uvc_q, rd1_q, rd2_q, ra1_q, ra2_q;
    logic            ma_q, mb_q, dl_q, syn_q, syn_prev_r;
    logic            det_prev_r;
    logic            run_ok;
    logic            sink_det;
    ucm_chg_t        mode_nxt;
    logic [1:0]      adv_nxt;

    // Filtered level: changes only once second and third stage agree
    function automatic logic filt(input logic [2:0] s, input logic q);
        filt = (s[1] == s[2]) ? s[2] : q;
    endfunction

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            en_sy_r  <= SYNC_RST;
            uvi_sy_r <= SYNC_RST;
            uvc_sy_r <= SYNC_RST;
            rd1_sy_r <= SYNC_RST;
            rd2_sy_r <= SYNC_RST;
            ra1_sy_r <= SYNC_RST;
            ra2_sy_r <= SYNC_RST;
            ma_sy_r  <= SYNC_RST;
            mb_sy_r  <= SYNC_RST;
            dl_sy_r  <= SYNC_RST;
            syn_sy_r <= SYNC_RST;
        end else begin
            en_sy_r  <= {en_sy_r[1:0], enable_in};
            uvi_sy_r <= {uvi_sy_r[1:0], vin_undervoltage_lockout};
            uvc_sy_r <= {uvc_sy_r[1:0], vcc_undervoltage_lockout};
            rd1_sy_r <= {rd1_sy_r[1:0], cc1_rd_det};
            rd2_sy_r <= {rd2_sy_r[1:0], cc2_rd_det};
            ra1_sy_r <= {ra1_sy_r[1:0], cc1_ra_det};
            ra2_sy_r <= {ra2_sy_r[1:0], cc2_ra_det};
            ma_sy_r  <= {ma_sy_r[1:0], charge_mode_select_a};
            mb_sy_r  <= {mb_sy_r[1:0], charge_mode_select_b};
            dl_sy_r  <= {dl_sy_r[1:0], dline_pull_det};
            syn_sy_r <= {syn_sy_r[1:0], freq_set_sync_input};
        end
    end

    // Filtered levels; lockouts reset to asserted so nothing runs early
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            en_q  <= RST_OFF;
            uvi_q <= RST_LOCK;
            uvc_q <= RST_LOCK;
            rd1_q <= RST_OFF;
            rd2_q <= RST_OFF;
            ra1_q <= RST_OFF;
            ra2_q <= RST_OFF;
            ma_q  <= RST_OFF;
            mb_q  <= RST_OFF;
            dl_q  <= RST_OFF;
            syn_q <= RST_OFF;
        end else begin
            en_q  <= filt(en_sy_r, en_q);
            uvi_q <= filt(uvi_sy_r, uvi_q);
            uvc_q <= filt(uvc_sy_r, uvc_q);
            rd1_q <= filt(rd1_sy_r, rd1_q);
            rd2_q <= filt(rd2_sy_r, rd2_q);
            ra1_q <= filt(ra1_sy_r, ra1_q);
            ra2_q <= filt(ra2_sy_r, ra2_q);
            ma_q  <= filt(ma_sy_r, ma_q);
            mb_q  <= filt(mb_sy_r, mb_q);
            dl_q  <= filt(dl_sy_r, dl_q);
            syn_q <= filt(syn_sy_r, syn_q);
        end
    end

    assign run_ok   = en_q && !uvi_q && !uvc_q;
    assign sink_det = rd1_q || rd2_q;

    // ************************************************************
    // Power mode sequencer
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state_r    <= UCM_SHUTDOWN;
            cnt_r      <= '0;
            det_prev_r <= RST_OFF;
        end else begin
            det_prev_r <= sink_det;
            if (!run_ok) begin
                state_r <= UCM_SHUTDOWN;
                cnt_r   <= '0;
            end else begin
                case (state_r)
                    UCM_SHUTDOWN: begin
                        // Enable sampled once input supply is good
                        state_r <= UCM_STARTUP;
                        cnt_r   <= '0;
                    end
                    UCM_STARTUP: begin
                        if (cnt_r >= CNT_W'(STARTUP - 1)) begin
                            state_r <= UCM_STANDBY;
                            cnt_r   <= '0;
                        end else begin
                            cnt_r <= cnt_r + 1'b1;
                        end
                    end
                    UCM_STANDBY: begin
                        cnt_r <= '0;
                        if (sink_det) begin
                            state_r <= UCM_DEBOUNCE;
                        end
                    end
                    UCM_DEBOUNCE: begin
                        if (!sink_det) begin
                            state_r <= UCM_STANDBY;
                            cnt_r   <= '0;
                        end else if (sink_det != det_prev_r) begin
                            cnt_r <= '0;
                        end else if (cnt_r >= CNT_W'(ATTACH_DEB - 1)) begin
                            state_r <= UCM_ACTIVE;
                            cnt_r   <= '0;
                        end else begin
                            cnt_r <= cnt_r + 1'b1;
                        end
                    end
                    UCM_ACTIVE: begin
                        if (!sink_det) begin
                            state_r <= UCM_STANDBY;
                        end
                    end
                    default: state_r <= UCM_SHUTDOWN;
                endcase
            end
        end
    end

    // ************************************************************
    // Charging mode decode
    // ************************************************************
    always_comb begin
        mode_nxt = UCM_CHG_NONE;
        adv_nxt  = ADV_DEFAULT;
        // Reserved codes advertise default and pick no charging mode
        case ({ma_q, mb_q})
            2'h2: begin
                mode_nxt = UCM_CHG_SDP;
                adv_nxt  = ADV_1A5;
            end
            2'h3: begin
                mode_nxt = UCM_CHG_CDP;
                adv_nxt  = ADV_3A;
            end
            2'h1: begin
                if (THERM_VARIANT) begin
                    mode_nxt = UCM_CHG_DCP;
                    adv_nxt  = ADV_3A;
                end
            end
            default: begin
                mode_nxt = UCM_CHG_NONE;
                adv_nxt  = ADV_DEFAULT;
            end
        endcase
    end

    // Advertisement stays on while powered; charge mode only once active
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            cc_adv_level <= ADV_DEFAULT;
            chg_mode     <= UCM_CHG_NONE;
        end else begin
            cc_adv_level <= (state_r != UCM_SHUTDOWN) ? adv_nxt : ADV_DEFAULT;
            // Type-C first, charging behaviour after attach
            chg_mode <= (state_r == UCM_ACTIVE) ? mode_nxt : UCM_CHG_NONE;
        end
    end

    // ************************************************************
    // DCP-auto line scheme machine
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            dcp_r    <= UCM_D_DIV3;
            hv_cnt_r <= '0;
        end else if (chg_mode != UCM_CHG_DCP) begin
            dcp_r    <= UCM_D_DIV3;
            hv_cnt_r <= '0;
        end else begin
            case (dcp_r)
                UCM_D_DIV3: begin
                    hv_cnt_r <= '0;
                    if (dl_q) begin
                        dcp_r <= UCM_D_1V2;
                    end
                end
                UCM_D_1V2: begin
                    if (!dl_q) begin
                        dcp_r <= UCM_D_DIV3;
                    end else if (hv_cnt_r >= CNT_W'(HV_HOLD - 1)) begin
                        dcp_r <= UCM_D_SHORT;
                    end else begin
                        hv_cnt_r <= hv_cnt_r + 1'b1;
                    end
                end
                UCM_D_SHORT: begin
                    if (!dl_q) begin
                        dcp_r <= UCM_D_DIV3;
                    end
                end
                default: dcp_r <= UCM_D_DIV3;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            dcp_scheme <= DCP_DIV3;
        end else begin
            case (dcp_r)
                UCM_D_1V2:   dcp_scheme <= DCP_1V2;
                UCM_D_SHORT: dcp_scheme <= DCP_SHORT;
                default:     dcp_scheme <= DCP_DIV3;
            endcase
        end
    end

    // ************************************************************
    // External sync detection
    // ************************************************************
    // Lock holds while edges keep arriving; falls back to own oscillator
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            syn_prev_r  <= RST_OFF;
            sync_cnt_r  <= '0;
            sync_locked <= RST_OFF;
        end else begin
            syn_prev_r <= syn_q;
            if (syn_q && !syn_prev_r) begin
                sync_cnt_r  <= '0;
                sync_locked <= 1'b1;
            end else if (sync_cnt_r >= CNT_W'(SYNC_LOSS_CYC)) begin
                sync_locked <= RST_OFF;
            end else begin
                sync_cnt_r <= sync_cnt_r + 1'b1;
            end
        end
    end

    // ************************************************************
    // Power and port outputs
    // ************************************************************
    // Gate turns on one cycle after buck and off with it or one cycle later, so the switch never leads
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            buck_enable            <= RST_OFF;
            forced_continuous_pwm  <= RST_OFF;
            spread_spectrum_en     <= RST_OFF;
            load_switch_gate_drive <= RST_OFF;
        end else begin
            buck_enable            <= (state_r == UCM_ACTIVE) && run_ok;
            forced_continuous_pwm  <= (state_r == UCM_ACTIVE);
            spread_spectrum_en     <= (state_r == UCM_ACTIVE);
            load_switch_gate_drive <= buck_enable && (state_r == UCM_ACTIVE);
        end
    end

    // VCONN only to the line opposite the sink carrying a cable plug
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            vconn_cc1_en            <= RST_OFF;
            vconn_cc2_en            <= RST_OFF;
            data_switch_en          <= RST_OFF;
            load_detect_output      <= RST_OFF;
            plug_orientation_output <= RST_OFF;
        end else begin
            // Lockout or enable loss drops VCONN at once, together with the buck
            vconn_cc1_en <= (state_r == UCM_ACTIVE) && run_ok && rd2_q && ra1_q;
            vconn_cc2_en <= (state_r == UCM_ACTIVE) && run_ok && rd1_q && ra2_q;
            data_switch_en <= !THERM_VARIANT && (state_r == UCM_ACTIVE) && en_q
                              && ((mode_nxt == UCM_CHG_SDP) || (mode_nxt == UCM_CHG_CDP));
            load_detect_output      <= (state_r == UCM_ACTIVE);
            plug_orientation_output <= (state_r == UCM_ACTIVE) && rd2_q && !rd1_q;
        end
    end

endmodule

// ==== tb/ucm_mode_monitor.sv ====
`timescale 1ns/1ps

module ucm_mode_monitor #(
    parameter int ATTACH_DEB = 8
) (
    // Clock and reset
    input wire logic              clk_sys,
    input wire logic              rst_b,
    // Pins
    input wire logic              enable_in,
    input wire logic              vin_undervoltage_lockout,
    input wire logic              vcc_undervoltage_lockout,
    input wire logic              cc1_rd_det,
    input wire logic              cc2_rd_det,
    input wire logic              charge_mode_select_a,
    input wire logic              charge_mode_select_b,
    input wire logic              dline_pull_det,
    // Outputs watched
    input wire logic              buck_enable,
    input wire logic              forced_continuous_pwm,
    input wire logic              spread_spectrum_en,
    input wire logic              load_switch_gate_drive,
    input wire logic              vconn_cc1_en,
    input wire logic              vconn_cc2_en,
    input wire logic [1:0]        cc_adv_level,
    input wire ucm_pkg::ucm_chg_t chg_mode,
    input wire logic [1:0]        dcp_scheme
);
    import ucm_pkg::*;

    default clocking mon_cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // ************************************************************
    // Helper: cycles with every start condition met at the pins
    // ************************************************************
    logic [15:0] go_cnt_r;
    logic        go_raw;
    assign go_raw = enable_in && !vin_undervoltage_lockout && !vcc_undervoltage_lockout
                    && (cc1_rd_det || cc2_rd_det);
    // Saturates so a long session cannot wrap back below the limit
    always_ff @(posedge clk_sys) begin
        if (!rst_b || !go_raw) go_cnt_r <= 16'h0000;
        else if (go_cnt_r != 16'hFFFF) go_cnt_r <= go_cnt_r + 16'h0001;
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    shutdown_off_a: assert property (!enable_in [*8] |-> !buck_enable)
        else $error("buck running while enable is low");
    lockout_off_a: assert property (vin_undervoltage_lockout [*8] |-> !buck_enable)
        else $error("buck running under input lockout");
    standby_off_a: assert property ((!cc1_rd_det && !cc2_rd_det) [*8] |-> !buck_enable)
        else $error("buck running with no sink");
    debounced_start_a: assert property ($rose(buck_enable) |-> go_cnt_r >= ATTACH_DEB)
        else $error("buck started before conditions held for the debounce");
    pwm_mode_a: assert property (buck_enable |-> forced_continuous_pwm && spread_spectrum_en)
        else $error("active without forced pwm and dither");
    gate_on_a: assert property ($rose(buck_enable) |=> load_switch_gate_drive)
        else $error("gate not on one cycle after buck");
    gate_off_a: assert property ($fell(buck_enable) |=> !load_switch_gate_drive)
        else $error("gate left on after buck stopped");
    mode_follow_a: assert property (
        ({charge_mode_select_a, charge_mode_select_b} == 2'b11 && buck_enable) [*8]
        |-> chg_mode == UCM_CHG_CDP && cc_adv_level == ADV_3A)
        else $error("mode does not follow control pins");
    vconn_one_a: assert property (vconn_cc1_en |-> buck_enable && !vconn_cc2_en)
        else $error("vconn outside active or on both lines");
    dcp_release_a: assert property ((chg_mode == UCM_CHG_DCP && !dline_pull_det) [*8]
        |-> dcp_scheme == DCP_DIV3)
        else $error("dcp scheme not divider after release");
    dcp_path_a: assert property (
        $rose(dcp_scheme == DCP_SHORT) |-> $past(dcp_scheme) == DCP_1V2)
        else $error("shorted entered without 1.2 V step");

    // Main scenarios reached
    cov_active_c: cover property ($rose(buck_enable));
    cov_short_c: cover property (dcp_scheme == DCP_SHORT);
    cov_vconn_c: cover property (vconn_cc1_en);
endmodule

bind ucm_mode_ctrl ucm_mode_monitor #(.ATTACH_DEB(ATTACH_DEB)) mon_u (
    .clk_sys, .rst_b, .enable_in, .vin_undervoltage_lockout, .vcc_undervoltage_lockout,
    .cc1_rd_det, .cc2_rd_det, .charge_mode_select_a, .charge_mode_select_b, .dline_pull_det,
    .buck_enable, .forced_continuous_pwm, .spread_spectrum_en, .load_switch_gate_drive,
    .vconn_cc1_en, .vconn_cc2_en, .cc_adv_level, .chg_mode, .dcp_scheme
);

// ==== tb/ucm_sink_model.sv ====
`timescale 1ns/1ps

module ucm_sink_model (
    // Clock
    input  wire logic clk_sys,
    // Scenario commands
    input  wire logic attach,
    input  wire logic flip,
    input  wire logic cable,
    input  wire logic pull,
    // Line detections seen by the port
    output logic      cc1_rd_det = 1'b0,
    output logic      cc2_rd_det = 1'b0,
    output logic      cc1_ra_det = 1'b0,
    output logic      cc2_ra_det = 1'b0,
    output logic      dline_pull_det = 1'b0
);
    // Rd on the sink side; plug Ra appears on the opposite line
    always @(negedge clk_sys) begin
        cc1_rd_det <= attach && !flip;
        cc2_rd_det <= attach && flip;
        cc1_ra_det <= attach && cable && flip;
        cc2_ra_det <= attach && cable && !flip;
    end
    // Host side taken as running, so SDP and CDP charging is allowed
    // Handshake loading of the data lines, only while plugged in
    always @(negedge clk_sys) begin
        dline_pull_det <= attach && pull;
    end
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ps

module tb;
    import ucm_pkg::*;
    localparam int DEB = 8;
    localparam int HV  = 8;
    // Pins and commands
    logic       clk_sys, rst_b, enable_in, vin_undervoltage_lockout, vcc_undervoltage_lockout;
    logic       charge_mode_select_a, charge_mode_select_b, freq_set_sync_input;
    logic       attach, flip, cable, pull;
    logic       cc1_rd_det, cc2_rd_det, cc1_ra_det, cc2_ra_det, dline_pull_det;
    logic       buck_enable, forced_continuous_pwm, spread_spectrum_en, sync_locked;
    logic       load_switch_gate_drive, vconn_cc1_en, vconn_cc2_en, data_switch_en;
    logic       load_detect_output, plug_orientation_output;
    logic [1:0] cc_adv_level, dcp_scheme;
    ucm_chg_t   chg_mode;
    int         error_cnt = 0;
    int         tests_run = 0;
    int         n;

    ucm_mode_ctrl #(.THERM_VARIANT(1'b1), .ATTACH_DEB(DEB), .STARTUP(4), .HV_HOLD(HV)) dut_u (
        .clk_sys, .rst_b, .enable_in, .vin_undervoltage_lockout, .vcc_undervoltage_lockout,
        .cc1_rd_det, .cc2_rd_det, .cc1_ra_det, .cc2_ra_det, .charge_mode_select_a,
        .charge_mode_select_b, .dline_pull_det, .freq_set_sync_input, .buck_enable,
        .forced_continuous_pwm, .spread_spectrum_en, .sync_locked, .load_switch_gate_drive,
        .vconn_cc1_en, .vconn_cc2_en, .cc_adv_level, .chg_mode, .dcp_scheme, .data_switch_en,
        .load_detect_output, .plug_orientation_output);
    ucm_sink_model sink_u (.clk_sys, .attach, .flip, .cable, .pull, .cc1_rd_det, .cc2_rd_det,
        .cc1_ra_det, .cc2_ra_det, .dline_pull_det);

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk_sys);
    endtask
    // Bounded wait for the buck to reach a level; count kept in n
    task automatic wait_buck(input logic lvl);
        n = 0;
        while (buck_enable !== lvl && n < 300) begin
            @(negedge clk_sys);
            n++;
        end
        chk("buck level reached", 4'(lvl), 4'(buck_enable));
    endtask
    task automatic plug(input logic [1:0] code);
        {charge_mode_select_a, charge_mode_select_b} = code;
        attach = 1'b1;
        wait_buck(1'b1);
        cyc(1);
    endtask
    task automatic unplug;
        attach = 1'b0;
        wait_buck(1'b0);
        cyc(2);
        chk("gate off", 4'h0, 4'(load_switch_gate_drive));
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_standby;
        cyc(40);
        chk("standby buck", 4'h0, 4'(buck_enable));
        chk("standby load detect", 4'h0, 4'(load_detect_output));
        chk("standby mode", 4'(UCM_CHG_NONE), 4'(chg_mode));
        $display("test standby done");
    endtask
    task automatic t_modes;
        logic [1:0] codes [3] = '{2'b10, 2'b11, 2'b01};
        ucm_chg_t   modes [3] = '{UCM_CHG_SDP, UCM_CHG_CDP, UCM_CHG_DCP};
        logic [1:0] advs  [3] = '{ADV_1A5, ADV_3A, ADV_3A};
        for (int i = 0; i < 3; i++) begin
            plug(codes[i]);
            chk("debounce wait", 4'h1, 4'(n >= DEB));
            chk("mode", 4'(modes[i]), 4'(chg_mode));
            chk("advertise", 4'(advs[i]), 4'(cc_adv_level));
            chk("pwm dither", 4'h3, {2'b00, forced_continuous_pwm, spread_spectrum_en});
            chk("gate on", 4'h1, 4'(load_switch_gate_drive));
            chk("load detect", 4'h1, 4'(load_detect_output));
            chk("data switch", 4'h0, 4'(data_switch_en));
            unplug();
        end
        $display("test modes done");
    endtask
    task automatic t_follow;
        plug(2'b11);
        cyc(8);
        {charge_mode_select_a, charge_mode_select_b} = 2'b10;
        cyc(8);
        chk("follow mode", 4'(UCM_CHG_SDP), 4'(chg_mode));
        chk("follow adv", 4'(ADV_1A5), 4'(cc_adv_level));
        {charge_mode_select_a, charge_mode_select_b} = 2'b00;
        cyc(8);
        chk("reserved mode", 4'(UCM_CHG_NONE), 4'(chg_mode));
        chk("reserved adv", 4'(ADV_DEFAULT), 4'(cc_adv_level));
        unplug();
        $display("test follow done");
    endtask
    task automatic t_bounce;
        logic seen = 1'b0;
        // Attach shorter than the debounce, repeatedly
        for (int i = 0; i < 36; i++) begin
            attach = (i % 9) < 6;
            @(negedge clk_sys);
            seen |= buck_enable;
        end
        chk("bounce no start", 4'h0, 4'(seen));
        plug(2'b11);
        unplug();
        $display("test bounce done");
    endtask
    task automatic t_vconn;
        flip = 1'b1;
        cable = 1'b1;
        plug(2'b10);
        chk("vconn lines", 4'h2, {2'b00, vconn_cc1_en, vconn_cc2_en});
        chk("reverse plug", 4'h1, 4'(plug_orientation_output));
        unplug();
        chk("vconn off", 4'h0, 4'(vconn_cc1_en));
        flip = 1'b0;
        cable = 1'b0;
        $display("test vconn done");
    endtask
    task automatic t_dcp;
        plug(2'b01);
        chk("dcp start", 4'(DCP_DIV3), 4'(dcp_scheme));
        pull = 1'b1;
        cyc(7);
        chk("dcp 1v2", 4'(DCP_1V2), 4'(dcp_scheme));
        cyc(HV + 4);
        chk("dcp shorted", 4'(DCP_SHORT), 4'(dcp_scheme));
        pull = 1'b0;
        cyc(8);
        chk("dcp release", 4'(DCP_DIV3), 4'(dcp_scheme));
        unplug();
        $display("test dcp done");
    endtask
    task automatic t_sync;
        repeat (6) begin
            freq_set_sync_input = 1'b1;
            cyc(4);
            freq_set_sync_input = 1'b0;
            cyc(4);
        end
        chk("sync lock", 4'h1, 4'(sync_locked));
        cyc(80);
        chk("sync lost", 4'h0, 4'(sync_locked));
        $display("test sync done");
    endtask
    task automatic t_power;
        plug(2'b11);
        enable_in = 1'b0;
        wait_buck(1'b0);
        chk("enable off time", 4'h1, 4'(n <= 8));
        vin_undervoltage_lockout = 1'b1;
        cyc(6);
        vin_undervoltage_lockout = 1'b0;
        cyc(40);
        chk("enable sampled low", 4'h0, 4'(buck_enable));
        enable_in = 1'b1;
        wait_buck(1'b1);
        vin_undervoltage_lockout = 1'b1;
        wait_buck(1'b0);
        chk("vin lockout time", 4'h1, 4'(n <= 8));
        cyc(4);
        vin_undervoltage_lockout = 1'b0;
        wait_buck(1'b1);
        vcc_undervoltage_lockout = 1'b1;
        wait_buck(1'b0);
        chk("vcc lockout time", 4'h1, 4'(n <= 8));
        vcc_undervoltage_lockout = 1'b0;
        unplug();
        $display("test power done");
    endtask

    // ************************************************************
    // Clock, run and verdict
    // ************************************************************
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Whole run needs several hundred cycles; far beyond that is a hang
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        {rst_b, vin_undervoltage_lockout, vcc_undervoltage_lockout} = 3'b000;
        {enable_in, charge_mode_select_a, charge_mode_select_b} = 3'b111;
        {freq_set_sync_input, attach, flip, cable, pull} = 5'h00;
        cyc(16);
        rst_b = 1'b1;
        t_standby();
        t_modes();
        t_follow();
        t_bounce();
        t_vconn();
        t_dcp();
        t_sync();
        t_power();
        report_and_stop();
    end
endmodule
